// *** rtl/nvram_command_register_access.sv ***
// Host and local-side command registers driving one external memory access engine
//
// Behaviour
// - Command 100 selects low address loading; later data-byte writes overwrite it.
// - Command 101 selects high address loading; later data-byte writes overwrite it.
// - Address is 11 bits; only three low bits of the high byte count.
// - Command 111 sets busy and starts a memory read at the loaded address.
// - After a read, bits 23:16 show the byte read from memory.
// - Transfer-failure bit 28 sets when the memory gives no acknowledge.
// - Failure flag holds until the next read or write operation begins.
// - A wide write carries command and data byte together in one access.
// - Wide write with 100 or 101 loads its byte straight into that address.
// - Wide write of 110 loads write data, sets busy, starts a memory write.
// - Byte-wide command 000 drops address loading and selects write-data loading.
// - Only one of the three load selections is active at a time.
// - Identical local-side register shares the engine through queueing and arbitration.
// - After an acknowledged write, memory is re-addressed until it acknowledges or 4096 probes go unanswered; then busy clears.
`timescale 1ns/1ns
module nvram_command_register_access (
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    // Host-side control register
    input wire logic HOST_WR_I,
    input wire logic [3:0] HOST_BE_I,
    input wire logic [nvram_pkg::REG_W-1:0] HOST_WDATA_I,
    output logic [nvram_pkg::REG_W-1:0] HOST_RDATA_O,
    // Local add-on side control register
    input wire logic LOCAL_WR_I,
    input wire logic [3:0] LOCAL_BE_I,
    input wire logic [nvram_pkg::REG_W-1:0] LOCAL_WDATA_I,
    output logic [nvram_pkg::REG_W-1:0] LOCAL_RDATA_O,
    // External memory transaction port
    output logic MEM_REQ_O,
    output logic [1:0] MEM_OP_O,
    output logic [nvram_pkg::ADDR_W-1:0] MEM_ADDR_O,
    output logic [nvram_pkg::BYTE_W-1:0] MEM_WDATA_O,
    input wire logic MEM_DONE_I,
    input wire logic MEM_ACK_I,
    input wire logic [nvram_pkg::BYTE_W-1:0] MEM_RDATA_I
);

    localparam int NS = nvram_pkg::NSIDES;

    // Command lane write with a start command
    function automatic logic is_start(input logic cmd_wr, input nvram_pkg::cmd_t cmd);
        is_start = cmd_wr && ((cmd == nvram_pkg::CMD_WRITE) || (cmd == nvram_pkg::CMD_READ));
    endfunction

    // Where a data byte goes: the command in the same access wins over the held selection
    function automatic nvram_pkg::load_sel_e data_target(
        input logic cmd_wr,
        input nvram_pkg::cmd_t cmd,
        input nvram_pkg::load_sel_e held
    );
        data_target = held;
        if (cmd_wr) begin
            unique case (cmd)
                nvram_pkg::CMD_LOAD_LOW: data_target = nvram_pkg::SEL_LOW;
                nvram_pkg::CMD_LOAD_HIGH: data_target = nvram_pkg::SEL_HIGH;
                nvram_pkg::CMD_SEL_WDATA: data_target = nvram_pkg::SEL_WDATA;
                nvram_pkg::CMD_WRITE: data_target = nvram_pkg::SEL_WDATA;
                default: data_target = nvram_pkg::SEL_NONE;
            endcase
        end
    endfunction

    // Register read image
    function automatic logic [nvram_pkg::REG_W-1:0] status_word(
        input logic busy,
        input logic fail,
        input logic [nvram_pkg::BYTE_W-1:0] data
    );
        status_word = nvram_pkg::REG_ZERO;
        status_word[nvram_pkg::BUSY_BIT] = busy;
        status_word[nvram_pkg::FAIL_BIT] = fail;
        status_word[nvram_pkg::DATA_HI:nvram_pkg::DATA_LO] = data;
    endfunction

    // Local side is staged one cycle, mirroring its longer path to the engine
    logic local_wr_q;
    logic [3:0] local_be_q;
    logic [nvram_pkg::REG_W-1:0] local_wdata_q;

    logic side_wr [NS];
    logic [3:0] side_be [NS];
    logic [nvram_pkg::REG_W-1:0] side_wd [NS];

    nvram_pkg::load_sel_e sel_q [NS];
    nvram_pkg::load_sel_e sel_d [NS];
    logic [nvram_pkg::BYTE_W-1:0] lo_q [NS];
    logic [nvram_pkg::BYTE_W-1:0] lo_d [NS];
    logic [nvram_pkg::BYTE_W-1:0] hi_q [NS];
    logic [nvram_pkg::BYTE_W-1:0] hi_d [NS];
    logic [nvram_pkg::BYTE_W-1:0] wdat_q [NS];
    logic [nvram_pkg::BYTE_W-1:0] wdat_d [NS];
    logic start_d [NS];
    logic busy_q [NS];
    logic fail_q [NS];
    logic [nvram_pkg::BYTE_W-1:0] rdat_q [NS];
    logic pend_q [NS];
    nvram_pkg::mem_cmd_s pcmd_q [NS];

    logic grant_valid;
    logic grant_side;
    logic last_side_q;
    logic owner_q;
    logic eng_start_q;
    nvram_pkg::mem_cmd_s eng_cmd_q;
    logic eng_busy;
    logic eng_done;
    logic eng_fail;
    logic [nvram_pkg::BYTE_W-1:0] eng_rdata;
    nvram_pkg::mem_op_e eng_op;

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            local_wr_q <= 1'b0;
            local_be_q <= 4'h0;
            local_wdata_q <= nvram_pkg::REG_ZERO;
        end else begin
            local_wr_q <= LOCAL_WR_I;
            local_be_q <= LOCAL_BE_I;
            local_wdata_q <= LOCAL_WDATA_I;
        end
    end

    always_comb begin
        side_wr[nvram_pkg::SIDE_HOST] = HOST_WR_I;
        side_be[nvram_pkg::SIDE_HOST] = HOST_BE_I;
        side_wd[nvram_pkg::SIDE_HOST] = HOST_WDATA_I;
        side_wr[nvram_pkg::SIDE_LOCAL] = local_wr_q;
        side_be[nvram_pkg::SIDE_LOCAL] = local_be_q;
        side_wd[nvram_pkg::SIDE_LOCAL] = local_wdata_q;
    end

    // Decode of each side's register write
    always_comb begin
        for (int s = 0; s < NS; s++) begin
            logic cw;
            logic dw;
            nvram_pkg::cmd_t cmd;
            logic [nvram_pkg::BYTE_W-1:0] dat;
            nvram_pkg::load_sel_e tgt;
            cw = side_wr[s] && side_be[s][nvram_pkg::BE_CMD];
            dw = side_wr[s] && side_be[s][nvram_pkg::BE_DATA];
            cmd = side_wd[s][nvram_pkg::CMD_HI:nvram_pkg::CMD_LO];
            dat = side_wd[s][nvram_pkg::DATA_HI:nvram_pkg::DATA_LO];
            // Wide write: command and byte in one access
            tgt = data_target(cw, cmd, sel_q[s]);
            sel_d[s] = sel_q[s];
            if (cw) begin
                unique case (cmd)
                    nvram_pkg::CMD_LOAD_LOW: sel_d[s] = nvram_pkg::SEL_LOW;
                    nvram_pkg::CMD_LOAD_HIGH: sel_d[s] = nvram_pkg::SEL_HIGH;
                    nvram_pkg::CMD_SEL_WDATA: sel_d[s] = nvram_pkg::SEL_WDATA;
                    nvram_pkg::CMD_WRITE: sel_d[s] = nvram_pkg::SEL_NONE;
                    nvram_pkg::CMD_READ: sel_d[s] = nvram_pkg::SEL_NONE;
                    default: sel_d[s] = sel_q[s];
                endcase
            end
            lo_d[s] = lo_q[s];
            hi_d[s] = hi_q[s];
            wdat_d[s] = wdat_q[s];
            if (dw) begin
                unique case (tgt)
                    nvram_pkg::SEL_LOW: lo_d[s] = dat;
                    nvram_pkg::SEL_HIGH: hi_d[s] = dat;
                    nvram_pkg::SEL_WDATA: wdat_d[s] = dat;
                    nvram_pkg::SEL_NONE: wdat_d[s] = wdat_q[s];
                endcase
            end
            // A start while busy is dropped; software must poll first
            start_d[s] = is_start(cw, cmd) && !busy_q[s];
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            for (int s = 0; s < NS; s++) begin
                sel_q[s] <= nvram_pkg::SEL_NONE;
            end
        end else begin
            for (int s = 0; s < NS; s++) begin
                sel_q[s] <= sel_d[s];
            end
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            for (int s = 0; s < NS; s++) begin
                lo_q[s] <= nvram_pkg::BYTE_ZERO;
                hi_q[s] <= nvram_pkg::BYTE_ZERO;
                wdat_q[s] <= nvram_pkg::BYTE_ZERO;
            end
        end else begin
            for (int s = 0; s < NS; s++) begin
                lo_q[s] <= lo_d[s];
                hi_q[s] <= hi_d[s];
                wdat_q[s] <= wdat_d[s];
            end
        end
    end

    // Queued operation per side, captured with the same-cycle data byte
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            for (int s = 0; s < NS; s++) begin
                pend_q[s] <= 1'b0;
                pcmd_q[s] <= nvram_pkg::MEM_CMD_RESET;
            end
        end else begin
            for (int s = 0; s < NS; s++) begin
                if (start_d[s]) begin
                    pend_q[s] <= 1'b1;
                    pcmd_q[s].is_read <= (side_wd[s][nvram_pkg::CMD_HI:nvram_pkg::CMD_LO]
                                          == nvram_pkg::CMD_READ);
                    pcmd_q[s].addr <= {hi_d[s][nvram_pkg::HIGH_USED-1:0], lo_d[s]};
                    pcmd_q[s].wdata <= wdat_d[s];
                end else if (grant_valid && (grant_side == s[0])) begin
                    pend_q[s] <= 1'b0;
                end
            end
        end
    end

    // Round-robin between the two sides, only while the engine is free
    always_comb begin
        grant_valid = 1'b0;
        grant_side = 1'b0;
        if (!eng_busy && !eng_start_q) begin
            if (pend_q[0] && pend_q[1]) begin
                grant_valid = 1'b1;
                grant_side = !last_side_q;
            end else if (pend_q[0] || pend_q[1]) begin
                grant_valid = 1'b1;
                grant_side = pend_q[1];
            end
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            eng_start_q <= 1'b0;
            eng_cmd_q <= nvram_pkg::MEM_CMD_RESET;
            owner_q <= 1'b0;
            last_side_q <= 1'b1;
        end else begin
            eng_start_q <= grant_valid;
            if (grant_valid) begin
                eng_cmd_q <= pcmd_q[grant_side];
                owner_q <= grant_side;
                last_side_q <= grant_side;
            end
        end
    end

    // Busy, failure and read-back byte per side
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            for (int s = 0; s < NS; s++) begin
                busy_q[s] <= 1'b0;
                fail_q[s] <= 1'b0;
                rdat_q[s] <= nvram_pkg::BYTE_ZERO;
            end
        end else begin
            for (int s = 0; s < NS; s++) begin
                if (start_d[s]) begin
                    busy_q[s] <= 1'b1;
                    fail_q[s] <= 1'b0;
                end else if (eng_done && (owner_q == s[0])) begin
                    busy_q[s] <= 1'b0;
                    fail_q[s] <= eng_fail;
                    if (eng_cmd_q.is_read) begin
                        rdat_q[s] <= eng_rdata;
                    end
                end
            end
        end
    end

    nvram_access_engine u_engine (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .start_i(eng_start_q),
        .cmd_i(eng_cmd_q),
        .busy_o(eng_busy),
        .done_o(eng_done),
        .fail_o(eng_fail),
        .rdata_o(eng_rdata),
        .mem_req_o(MEM_REQ_O),
        .mem_op_o(eng_op),
        .mem_addr_o(MEM_ADDR_O),
        .mem_wdata_o(MEM_WDATA_O),
        .mem_done_i(MEM_DONE_I),
        .mem_ack_i(MEM_ACK_I),
        .mem_rdata_i(MEM_RDATA_I)
    );

    assign MEM_OP_O = eng_op;
    assign HOST_RDATA_O = status_word(busy_q[nvram_pkg::SIDE_HOST], fail_q[nvram_pkg::SIDE_HOST],
                                      rdat_q[nvram_pkg::SIDE_HOST]);
    assign LOCAL_RDATA_O = status_word(busy_q[nvram_pkg::SIDE_LOCAL],
                                       fail_q[nvram_pkg::SIDE_LOCAL],
                                       rdat_q[nvram_pkg::SIDE_LOCAL]);

endmodule

// *** rtl/nvram_pkg.sv ***
// Shared constants, types and carriers for the nonvolatile memory command register
package nvram_pkg;

    // Control register field positions
    localparam int BUSY_BIT = 31;
    localparam int CMD_HI = 31;
    localparam int CMD_LO = 29;
    localparam int FAIL_BIT = 28;
    localparam int DATA_HI = 23;
    localparam int DATA_LO = 16;

    // Byte lanes: lane 3 carries the command, lane 2 the address/data byte
    localparam int BE_CMD = 3;
    localparam int BE_DATA = 2;

    localparam int REG_W = 32;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 11;
    localparam int HIGH_USED = 3;
    localparam int NSIDES = 2;
    localparam int SIDE_HOST = 0;
    localparam int SIDE_LOCAL = 1;

    typedef logic [2:0] cmd_t;
    localparam cmd_t CMD_SEL_WDATA = 3'h0;
    localparam cmd_t CMD_LOAD_LOW = 3'h4;
    localparam cmd_t CMD_LOAD_HIGH = 3'h5;
    localparam cmd_t CMD_WRITE = 3'h6;
    localparam cmd_t CMD_READ = 3'h7;

    localparam logic [REG_W-1:0] REG_ZERO = 32'h0000_0000;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

    // Acknowledge polls after a write before giving up
    localparam logic [11:0] POLL_LIMIT = 12'hFFF;
    localparam logic [11:0] POLL_ONE = 12'h001;

    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_LOW = 2'b01,
        SEL_HIGH = 2'b11,
        SEL_WDATA = 2'b10
    } load_sel_e;

    typedef enum logic [1:0] {
        MOP_WRITE = 2'h0,
        MOP_READ = 2'h1,
        MOP_PROBE = 2'h2
    } mem_op_e;

    typedef enum logic [1:0] {
        ENG_IDLE = 2'b00,
        ENG_XFER = 2'b01,
        ENG_POLL = 2'b11
    } eng_state_e;

    typedef struct packed {
        logic is_read;
        logic [ADDR_W-1:0] addr;
        logic [BYTE_W-1:0] wdata;
    } mem_cmd_s;

    localparam mem_cmd_s MEM_CMD_RESET = '{is_read: 1'b0, addr: 11'h000, wdata: 8'h00};

endpackage

// *** rtl/nvram_access_engine.sv ***
// Sequencer that runs one read or write on the external memory, with acknowledge polling
`timescale 1ns/1ns
module nvram_access_engine (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Command from the arbiter
    input wire logic start_i,
    input wire nvram_pkg::mem_cmd_s cmd_i,
    output logic busy_o,
    output logic done_o,
    output logic fail_o,
    output logic [nvram_pkg::BYTE_W-1:0] rdata_o,
    // Memory transaction port
    output logic mem_req_o,
    output nvram_pkg::mem_op_e mem_op_o,
    output logic [nvram_pkg::ADDR_W-1:0] mem_addr_o,
    output logic [nvram_pkg::BYTE_W-1:0] mem_wdata_o,
    input wire logic mem_done_i,
    input wire logic mem_ack_i,
    input wire logic [nvram_pkg::BYTE_W-1:0] mem_rdata_i
);

    nvram_pkg::eng_state_e state_q;
    nvram_pkg::mem_cmd_s cmd_q;
    logic [11:0] polls_q;

    assign busy_o = (state_q != nvram_pkg::ENG_IDLE);
    assign mem_addr_o = cmd_q.addr;
    assign mem_wdata_o = cmd_q.wdata;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= nvram_pkg::ENG_IDLE;
            cmd_q <= nvram_pkg::MEM_CMD_RESET;
            mem_req_o <= 1'b0;
            mem_op_o <= nvram_pkg::MOP_WRITE;
            polls_q <= 12'h000;
            done_o <= 1'b0;
            fail_o <= 1'b0;
            rdata_o <= nvram_pkg::BYTE_ZERO;
        end else begin
            done_o <= 1'b0;
            unique case (state_q)
                nvram_pkg::ENG_IDLE: begin
                    if (start_i) begin
                        cmd_q <= cmd_i;
                        mem_req_o <= 1'b1;
                        mem_op_o <= cmd_i.is_read ? nvram_pkg::MOP_READ : nvram_pkg::MOP_WRITE;
                        state_q <= nvram_pkg::ENG_XFER;
                    end
                end
                nvram_pkg::ENG_XFER: begin
                    if (mem_done_i) begin
                        mem_req_o <= 1'b0;
                        if (!mem_ack_i) begin
                            fail_o <= 1'b1;
                            done_o <= 1'b1;
                            state_q <= nvram_pkg::ENG_IDLE;
                        end else if (cmd_q.is_read) begin
                            rdata_o <= mem_rdata_i;
                            fail_o <= 1'b0;
                            done_o <= 1'b1;
                            state_q <= nvram_pkg::ENG_IDLE;
                        end else begin
                            // Memory is busy writing internally; keep addressing it
                            polls_q <= 12'h000;
                            state_q <= nvram_pkg::ENG_POLL;
                        end
                    end
                end
                nvram_pkg::ENG_POLL: begin
                    if (!mem_req_o) begin
                        mem_req_o <= 1'b1;
                        mem_op_o <= nvram_pkg::MOP_PROBE;
                    end else if (mem_done_i) begin
                        mem_req_o <= 1'b0;
                        if (mem_ack_i) begin
                            fail_o <= 1'b0;
                            done_o <= 1'b1;
                            state_q <= nvram_pkg::ENG_IDLE;
                        end else if (polls_q == nvram_pkg::POLL_LIMIT) begin
                            // Bounded so a dead memory cannot hold busy forever
                            fail_o <= 1'b1;
                            done_o <= 1'b1;
                            state_q <= nvram_pkg::ENG_IDLE;
                        end else begin
                            polls_q <= polls_q + nvram_pkg::POLL_ONE;
                        end
                    end
                end
                default: begin
                    mem_req_o <= 1'b0;
                    state_q <= nvram_pkg::ENG_IDLE;
                end
            endcase
        end
    end

endmodule

// *** tb/nvram_mem_model.sv ***
// Behavioural external memory on the design's transaction port
`timescale 1ns/1ns
module nvram_mem_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Scenario controls
    input wire logic [3:0] delay_i,
    input wire logic nack_i,
    input wire logic [3:0] probe_nacks_i,
    // Transaction port
    input wire logic req_i,
    input wire logic [1:0] op_i,
    input wire logic [10:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic done_o,
    output logic ack_o,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [0:2047];
    logic [3:0] cnt_q;
    logic [3:0] shut_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 4'h0;
            shut_q <= 4'h0;
            done_o <= 1'b0;
            ack_o <= 1'b0;
            rdata_o <= 8'hA5;
        end else if (req_i && !done_o && cnt_q == delay_i) begin
            done_o <= 1'b1;
            cnt_q <= 4'h0;
            if (op_i == 2'h2) begin
                ack_o <= (shut_q == 4'h0);
                if (shut_q != 4'h0) begin
                    shut_q <= shut_q - 4'h1;
                end
            end else begin
                ack_o <= !nack_i;
                rdata_o <= mem[addr_i];
                if (op_i == 2'h0 && !nack_i) begin
                    mem[addr_i] <= wdata_i;
                    shut_q <= probe_nacks_i;
                end
            end
        end else begin
            // Lines not valid outside a done pulse keep changing
            done_o <= 1'b0;
            ack_o <= !ack_o;
            rdata_o <= ~rdata_o;
            if (req_i && !done_o) begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
endmodule

// *** tb/nvram_command_register_access_sva.sv ***
// Concurrent checks on the command register and memory port
`timescale 1ns/1ns
module nvram_cmd_sva (
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    // Register ports
    input wire logic HOST_WR_I,
    input wire logic [3:0] HOST_BE_I,
    input wire logic [nvram_pkg::REG_W-1:0] HOST_WDATA_I,
    input wire logic [nvram_pkg::REG_W-1:0] HOST_RDATA_O,
    input wire logic LOCAL_WR_I,
    input wire logic [3:0] LOCAL_BE_I,
    input wire logic [nvram_pkg::REG_W-1:0] LOCAL_WDATA_I,
    input wire logic [nvram_pkg::REG_W-1:0] LOCAL_RDATA_O,
    // Memory port
    input wire logic MEM_REQ_O,
    input wire logic [1:0] MEM_OP_O,
    input wire logic [nvram_pkg::ADDR_W-1:0] MEM_ADDR_O,
    input wire logic [nvram_pkg::BYTE_W-1:0] MEM_WDATA_O,
    input wire logic MEM_DONE_I,
    input wire logic MEM_ACK_I,
    input wire logic [nvram_pkg::BYTE_W-1:0] MEM_RDATA_I
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);
    wire logic h_take = HOST_WR_I && HOST_BE_I[3] && !HOST_RDATA_O[31];
    wire logic fin = MEM_REQ_O && MEM_DONE_I;

    property p_reset_clear;
        $fell(RST_I) |-> HOST_RDATA_O == '0 && LOCAL_RDATA_O == '0 && !MEM_REQ_O;
    endproperty
    property p_read_busy;
        h_take && HOST_WDATA_I[31:29] == nvram_pkg::CMD_READ |=> HOST_RDATA_O[31];
    endproperty
    property p_write_busy;
        h_take && HOST_BE_I[2] && HOST_WDATA_I[31:29] == nvram_pkg::CMD_WRITE
            |=> HOST_RDATA_O[31] && !HOST_RDATA_O[28];
    endproperty
    property p_req_hold;
        MEM_REQ_O && !MEM_DONE_I |=> MEM_REQ_O && $stable(MEM_OP_O)
            && $stable(MEM_ADDR_O) && $stable(MEM_WDATA_O);
    endproperty
    property p_req_drop;
        fin |=> !MEM_REQ_O;
    endproperty
    property p_probe;
        fin && MEM_ACK_I && MEM_OP_O == 2'h0 |=> !MEM_REQ_O ##1 MEM_REQ_O && MEM_OP_O == 2'h2;
    endproperty
    property p_probe_busy;
        MEM_REQ_O && MEM_OP_O == 2'h2 |-> HOST_RDATA_O[31] || LOCAL_RDATA_O[31];
    endproperty
    property p_read_byte;
        fin && MEM_ACK_I && MEM_OP_O == 2'h1 |-> ##2
            HOST_RDATA_O[23:16] == $past(MEM_RDATA_I, 2)
            || LOCAL_RDATA_O[23:16] == $past(MEM_RDATA_I, 2);
    endproperty
    property p_nack_fail;
        fin && !MEM_ACK_I && MEM_OP_O != 2'h2 |-> ##2 HOST_RDATA_O[28] || LOCAL_RDATA_O[28];
    endproperty

    a_reset_clear: assert property (p_reset_clear) else $error("state not clear after reset");
    a_read_busy: assert property (p_read_busy) else $error("read start left busy low");
    a_write_busy: assert property (p_write_busy) else $error("write start wrong flags");
    a_req_hold: assert property (p_req_hold) else $error("request changed before done");
    a_req_drop: assert property (p_req_drop) else $error("request held after done");
    a_probe: assert property (p_probe) else $error("no probe after write");
    a_probe_busy: assert property (p_probe_busy) else $error("busy low while probing");
    a_read_byte: assert property (p_read_byte) else $error("read byte not shown");
    a_nack_fail: assert property (p_nack_fail) else $error("fail flag not set");

    c_probe: cover property (fin && MEM_OP_O == 2'h2 && MEM_ACK_I);
    c_nack: cover property (fin && !MEM_ACK_I && MEM_OP_O != 2'h2);
    c_local: cover property (LOCAL_WR_I && LOCAL_BE_I == 4'h8);
endmodule

bind nvram_command_register_access nvram_cmd_sva nvram_cmd_sva_i (
    .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .HOST_WR_I(HOST_WR_I), .HOST_BE_I(HOST_BE_I),
    .HOST_WDATA_I(HOST_WDATA_I), .HOST_RDATA_O(HOST_RDATA_O), .LOCAL_WR_I(LOCAL_WR_I),
    .LOCAL_BE_I(LOCAL_BE_I), .LOCAL_WDATA_I(LOCAL_WDATA_I), .LOCAL_RDATA_O(LOCAL_RDATA_O),
    .MEM_REQ_O(MEM_REQ_O), .MEM_OP_O(MEM_OP_O), .MEM_ADDR_O(MEM_ADDR_O),
    .MEM_WDATA_O(MEM_WDATA_O), .MEM_DONE_I(MEM_DONE_I), .MEM_ACK_I(MEM_ACK_I),
    .MEM_RDATA_I(MEM_RDATA_I)
);

// *** tb/tb_nvram_command_register_access.sv ***
// Self-checking bench for the memory command registers
`timescale 1ns/1ns
module tb_nvram_command_register_access;
    typedef struct packed {
        logic wr;
        logic nack;
        logic [7:0] lo;
        logic [7:0] hi;
        logic [7:0] d;
    } row_s;
    logic clk, rst, h_wr, l_wr, req, done, ack, nack;
    logic [3:0] h_be, l_be, delay, probes;
    logic [31:0] h_wdata, l_wdata, h_rdata, l_rdata;
    logic [1:0] op;
    logic [10:0] addr, seen_addr;
    logic [7:0] wdata, rdata, seen_wd, exp_b;
    int n_mismatch = 0, checks_done = 0, cycles = 0, n_probe = 0, p0;
    row_s rows [6] = '{'{1'b1, 1'b0, 8'h23, 8'hF9, 8'h5A}, '{1'b0, 1'b0, 8'h23, 8'h01, 8'h5A},
        '{1'b1, 1'b0, 8'hFF, 8'h07, 8'hA5}, '{1'b0, 1'b0, 8'hFF, 8'hFF, 8'hA5},
        '{1'b0, 1'b1, 8'h23, 8'h01, 8'h00}, '{1'b1, 1'b0, 8'h00, 8'h00, 8'h3C}};

    nvram_command_register_access nvram_command_register_access_i (
        .REF_CLK_I(clk), .RST_I(rst), .HOST_WR_I(h_wr), .HOST_BE_I(h_be),
        .HOST_WDATA_I(h_wdata), .HOST_RDATA_O(h_rdata), .LOCAL_WR_I(l_wr), .LOCAL_BE_I(l_be),
        .LOCAL_WDATA_I(l_wdata), .LOCAL_RDATA_O(l_rdata), .MEM_REQ_O(req), .MEM_OP_O(op),
        .MEM_ADDR_O(addr), .MEM_WDATA_O(wdata), .MEM_DONE_I(done), .MEM_ACK_I(ack),
        .MEM_RDATA_I(rdata));
    nvram_mem_model nvram_mem_model_i (
        .clk_i(clk), .rst_i(rst), .delay_i(delay), .nack_i(nack), .probe_nacks_i(probes),
        .req_i(req), .op_i(op), .addr_i(addr), .wdata_i(wdata), .done_o(done), .ack_o(ack),
        .rdata_o(rdata));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        if (req && op != 2'h2) begin
            seen_addr <= addr;
            seen_wd <= wdata;
        end
        if (req && done && op == 2'h2) n_probe <= n_probe + 1;
        cycles <= cycles + 1;
        // Ceiling well above the longest probe sequence
        if (cycles == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic loc, input logic [3:0] be, input logic [2:0] c,
                      input logic [7:0] d);
        @(posedge clk);
        {h_be, l_be} <= {be, be};
        {h_wdata, l_wdata} <= {2{c, 5'h00, d, 16'h0000}};
        h_wr <= !loc;
        l_wr <= loc;
        @(posedge clk);
        {h_wr, l_wr} <= 2'b00;
    endtask

    task automatic wait_idle(input logic loc);
        int n;
        n = 0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        while ((loc ? l_rdata[31] : h_rdata[31]) !== 1'b0 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        check(n < 5000, 1'b1);
    endtask

    // Wide-access sequence on the host side, then flag and data checks
    task automatic run(input row_s r);
        @(posedge clk);
        nack <= r.nack;
        wr(1'b0, 4'hC, 3'h4, r.lo);
        wr(1'b0, 4'hC, 3'h5, r.hi);
        wr(1'b0, 4'hC, r.wr ? 3'h6 : 3'h7, r.d);
        wait_idle(1'b0);
        if (!r.wr && !r.nack) exp_b = r.d;
        check(seen_addr, {r.hi[2:0], r.lo});
        check(h_rdata[28], r.nack);
        check(h_rdata[23:16], exp_b);
        if (r.wr) check(seen_wd, r.d);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        {h_wr, l_wr, nack, h_be, l_be, probes, h_wdata, l_wdata} = '0;
        delay = 4'h2;
        exp_b = 8'h00;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check(h_rdata | l_rdata, 32'h0);
        check(req, 1'b0);
        foreach (rows[i]) run(rows[i]);
        // Byte-wide on local side: overwrite low, high masked, 000 steers bytes to data
        wr(1'b1, 4'h8, 3'h4, 8'h00);
        wr(1'b1, 4'h4, 3'h0, 8'h11);
        wr(1'b1, 4'h4, 3'h0, 8'h45);
        wr(1'b1, 4'h8, 3'h5, 8'h00);
        wr(1'b1, 4'h4, 3'h0, 8'hFE);
        wr(1'b1, 4'hC, 3'h3, 8'h88);
        wr(1'b1, 4'h8, 3'h0, 8'h00);
        wr(1'b1, 4'h4, 3'h0, 8'h77);
        wr(1'b1, 4'h8, 3'h6, 8'h00);
        wait_idle(1'b1);
        check(seen_addr, 11'h645);
        check(seen_wd, 8'h77);
        run('{1'b0, 1'b0, 8'h45, 8'h06, 8'h77});
        // Memory busy for three probes after the write
        p0 = n_probe;
        @(posedge clk);
        probes <= 4'h3;
        run('{1'b1, 1'b0, 8'h10, 8'h02, 8'hC3});
        check(n_probe - p0, 4);
        // Refused write: failure sticks until the next start
        p0 = n_probe;
        run('{1'b1, 1'b1, 8'h11, 8'h02, 8'h99});
        check(n_probe - p0, 0);
        repeat (20) @(negedge clk);
        check(h_rdata[28], 1'b1);
        run('{1'b0, 1'b0, 8'h10, 8'h02, 8'hC3});
        // Reset in mid-read must drop everything
        @(posedge clk);
        delay <= 4'hF;
        wr(1'b0, 4'h8, 3'h7, 8'h00);
        repeat (4) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(negedge clk);
        check(h_rdata | l_rdata, 32'h0);
        check(req, 1'b0);
        print_verdict();
    end
endmodule
